// [rtl/ase_consts.svh]
// Constants for the acceleration status and motion event register slice
`ifndef ASE_CONSTS_SVH
`define ASE_CONSTS_SVH

// ****************************************
// Register addresses (7-bit)
// ****************************************
`define ASE_ADDR_STATUS 7'h27
`define ASE_ADDR_X_SMP 7'h29
`define ASE_ADDR_Y_SMP 7'h2b
`define ASE_ADDR_Z_SMP 7'h2d
`define ASE_ADDR_CFG 7'h30
`define ASE_ADDR_SRC 7'h31

// ****************************************
// Field positions and fixed values
// ****************************************
`define ASE_CFG_COMBINE 7
`define ASE_CFG_LATCH 6
`define ASE_SRC_ACTIVE 6
`define ASE_AXES 3
`define ASE_BYTE_ZERO 8'h00

`endif

// [rtl/ase_pkg.sv]
// Types for the acceleration status and motion event register slice
package ase_pkg;

  typedef enum logic {
    ase_lk_idle,
    ase_lk_wait
  } ase_lstate_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } ase_sync_t;

  typedef struct packed {
    logic [2:0][7:0] sample;
    logic [2:0] axis_nd;
    logic [2:0] axis_or;
    logic all_nd;
    logic all_or;
    logic [7:0] cfg;
    logic [7:0] src;
    logic [5:0] hl;
    logic ack_tgl;
    logic req_seen;
    logic [7:0] rdata;
  } ase_sys_t;

  typedef struct packed {
    ase_lstate_t st;
    logic busy;
    logic req_tgl;
    logic ack_seen;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } ase_link_t;

endpackage

// [rtl/ase_sync.sv]
// Two flip-flop synchroniser for one level or toggle
`timescale 1ns/10ps
module ase_sync
  import ase_pkg::*;
(
  input wire logic clk_i, // Destination clock
  input wire logic d_i,   // Level from another domain
  output logic q_o        // Synchronised level
);

  ase_sync_t s_q;
  ase_sync_t s_d;

  // No reset: the chain settles within two edges and resets may rely on it
  always_comb begin
    s_d.meta = d_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign q_o = s_q.stable;

endmodule

// [rtl/ase_core.sv]
// Acceleration status, sample output and motion event register slice
//
// Functional notes
// - Combined overrun sets when new data overwrites an unread full set.
// - Each axis overrun sets when its new sample overwrites an unread one.
// - Combined new-data rises once X, Y and Z samples are all new.
// - Each axis new-data flag sets when a new sample arrives.
// - Samples are 8-bit two's complement at three read-only addresses.
// - Enabled axis events combine by OR when select is 0, AND when 1.
// - Latch enable 1 holds event bits in the source register.
// - Host reads the source register to clear it; device clears it only with latch off.
// - Axis high event requested when enabled and magnitude above threshold.
// - Axis low event requested when enabled and magnitude below threshold.
// - Source register shows active flag and each occurred axis event.
// - Source read clears the interrupt output; with latch on, an event active in the same cycle keeps it set.
`timescale 1ns/10ps
`include "ase_consts.svh"
module ase_core
  import ase_pkg::*;
(
  input wire logic clk_sys_i,        // Sampling clock, 25 MHz
  input wire logic rst_n_i,          // Synchronous reset, active low
  input wire logic [7:0] smp_x_i,    // New X sample from conversion
  input wire logic [7:0] smp_y_i,    // New Y sample from conversion
  input wire logic [7:0] smp_z_i,    // New Z sample from conversion
  input wire logic [2:0] smp_vld_i,  // Sample strobes, bit0 X .. bit2 Z
  input wire logic [6:0] thresh_i,   // Event threshold, magnitude
  output logic motion_event_interrupt_o, // Event interrupt level
  input wire logic clk_link_i,       // Serial link clock
  input wire logic reg_req_i,        // Register access request pulse
  input wire logic reg_wr_i,         // 1 write, 0 read
  input wire logic [6:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o,    // Read data, valid with done
  output logic reg_done_o,           // Access finished pulse
  output logic reg_busy_o            // Access in flight
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [6:0] out_addr(input logic [1:0] ax);
    if (ax == 2'h0) begin
      return `ASE_ADDR_X_SMP;
    end else if (ax == 2'h1) begin
      return `ASE_ADDR_Y_SMP;
    end
    return `ASE_ADDR_Z_SMP;
  endfunction

  function automatic logic [7:0] mag(input logic [7:0] v);
    return v[7] ? 8'(~v + 8'h01) : v;
  endfunction

  // ****************************************
  // Domain crossing
  // ****************************************
  ase_sys_t s_q;
  ase_sys_t s_d;
  ase_link_t l_q;
  ase_link_t l_d;
  logic req_sync;
  logic ack_sync;
  logic lrst_n;

  ase_sync u_req_sync (
    .clk_i(clk_sys_i),
    .d_i(l_q.req_tgl),
    .q_o(req_sync)
  );

  ase_sync u_ack_sync (
    .clk_i(clk_link_i),
    .d_i(s_q.ack_tgl),
    .q_o(ack_sync)
  );

  ase_sync u_rst_sync (
    .clk_i(clk_link_i),
    .d_i(rst_n_i),
    .q_o(lrst_n)
  );

  // ****************************************
  // Access decode, sampling side
  // ****************************************
  // Link request fields are held stable while the toggle is in flight
  logic req_edge;
  logic acc_rd;
  logic acc_wr;
  logic src_rd;
  logic [2:0] rd_out;
  logic [2:0][7:0] smp_in;
  logic [5:0] hit;
  logic act;

  assign req_edge = req_sync != s_q.req_seen;
  assign acc_rd = req_edge && !l_q.wr;
  assign acc_wr = req_edge && l_q.wr;
  assign src_rd = acc_rd && (l_q.addr == `ASE_ADDR_SRC);
  assign smp_in = {smp_z_i, smp_y_i, smp_x_i};

  for (genvar g = 0; g < `ASE_AXES; g++) begin : g_axis
    assign rd_out[g] = acc_rd && (l_q.addr == out_addr(2'(g)));
  end

  // ****************************************
  // Event evaluation
  // ****************************************
  assign hit = s_q.cfg[5:0] & s_q.hl;
  // AND mode needs every enabled event; with none enabled nothing fires
  assign act = s_q.cfg[`ASE_CFG_COMBINE] ?
    ((|s_q.cfg[5:0]) && (&(s_q.hl | ~s_q.cfg[5:0]))) :
    (|hit);

  // ****************************************
  // Sampling side state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.req_seen = req_sync;
    if (req_edge) begin
      s_d.ack_tgl = ~s_q.ack_tgl;
    end
    for (int i = 0; i < `ASE_AXES; i++) begin
      if (rd_out[i]) begin
        s_d.axis_nd[i] = 1'b0;
        s_d.axis_or[i] = 1'b0;
      end
      // Arrival wins over a read in the same cycle
      if (smp_vld_i[i]) begin
        s_d.sample[i] = smp_in[i];
        s_d.axis_nd[i] = 1'b1;
        if (s_q.axis_nd[i]) begin
          s_d.axis_or[i] = 1'b1;
        end
      end
      s_d.hl[2*i+1] = mag(s_q.sample[i]) > {1'b0, thresh_i};
      s_d.hl[2*i] = mag(s_q.sample[i]) < {1'b0, thresh_i};
    end
    if (|rd_out) begin
      s_d.all_nd = 1'b0;
      s_d.all_or = 1'b0;
    end
    if ((|smp_vld_i) && s_q.all_nd) begin
      s_d.all_or = 1'b1;
    end
    if ((|smp_vld_i) && (&s_d.axis_nd)) begin
      s_d.all_nd = 1'b1;
    end
    if (acc_wr && (l_q.addr == `ASE_ADDR_CFG)) begin
      s_d.cfg = l_q.wdata;
    end
    if (s_q.cfg[`ASE_CFG_LATCH]) begin
      if (src_rd) begin
        s_d.src = `ASE_BYTE_ZERO;
      end
      if (act) begin
        s_d.src = s_d.src | {2'b01, hit};
      end
    end else if (src_rd) begin
      s_d.src = `ASE_BYTE_ZERO;
    end else begin
      s_d.src = {1'b0, act, hit};
    end
    if (acc_rd) begin
      if (l_q.addr == `ASE_ADDR_STATUS) begin
        s_d.rdata = {s_q.all_or, s_q.axis_or, s_q.all_nd,
          s_q.axis_nd};
      end else if (l_q.addr == `ASE_ADDR_X_SMP) begin
        s_d.rdata = s_q.sample[0];
      end else if (l_q.addr == `ASE_ADDR_Y_SMP) begin
        s_d.rdata = s_q.sample[1];
      end else if (l_q.addr == `ASE_ADDR_Z_SMP) begin
        s_d.rdata = s_q.sample[2];
      end else if (l_q.addr == `ASE_ADDR_CFG) begin
        s_d.rdata = s_q.cfg;
      end else if (l_q.addr == `ASE_ADDR_SRC) begin
        s_d.rdata = s_q.src;
      end else begin
        s_d.rdata = `ASE_BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign motion_event_interrupt_o = s_q.src[`ASE_SRC_ACTIVE];

  // ****************************************
  // Link side
  // ****************************************
  // The link clock must keep running until done, else the access stalls
  always_comb begin
    l_d = l_q;
    l_d.done = 1'b0;
    case (l_q.st)
      ase_lk_idle: begin
        if (reg_req_i) begin
          l_d.wr = reg_wr_i;
          l_d.addr = reg_addr_i;
          l_d.wdata = reg_wdata_i;
          l_d.req_tgl = ~l_q.req_tgl;
          l_d.busy = 1'b1;
          l_d.st = ase_lk_wait;
        end
      end
      ase_lk_wait: begin
        if (ack_sync != l_q.ack_seen) begin
          l_d.ack_seen = ack_sync;
          l_d.rdata = s_q.rdata;
          l_d.done = 1'b1;
          l_d.busy = 1'b0;
          l_d.st = ase_lk_idle;
        end
      end
      default: begin
        l_d.st = ase_lk_idle;
      end
    endcase
  end

  always_ff @(posedge clk_link_i) begin
    if (!lrst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign reg_rdata_o = l_q.rdata;
  assign reg_done_o = l_q.done;
  assign reg_busy_o = l_q.busy;

  // ****************************************
  // Checks
  // ****************************************
  chk_all_ovr_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (|smp_vld_i) && s_q.all_nd |=> s_q.all_or)
    else $error("combined overrun not set");

  chk_axis_ovr_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    smp_vld_i[0] && s_q.axis_nd[0] |=> s_q.axis_or[0])
    else $error("x overrun not set");

  chk_all_nd_full: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(s_q.all_nd) |-> (&s_q.axis_nd))
    else $error("combined new data before full set");

  chk_axis_nd_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    smp_vld_i[1] |=> s_q.axis_nd[1] ##1 (s_q.axis_nd[1] || $past(rd_out[1])))
    else $error("y new data not set");

  chk_sample_load: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    smp_vld_i[2] |=> s_q.sample[2] == $past(smp_z_i))
    else $error("z sample not loaded");

  chk_or_combine: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !s_q.cfg[`ASE_CFG_COMBINE] && (|hit) && !src_rd
    |=> s_q.src[`ASE_SRC_ACTIVE])
    else $error("or combination missed");

  chk_and_combine: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_q.cfg[`ASE_CFG_COMBINE] && !s_q.cfg[`ASE_CFG_LATCH] &&
    (hit != s_q.cfg[5:0]) |=> !s_q.src[`ASE_SRC_ACTIVE])
    else $error("and combination fired early");

  chk_latch_hold: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_q.cfg[`ASE_CFG_LATCH] && s_q.src[`ASE_SRC_ACTIVE] && !src_rd &&
    $stable(s_q.cfg) |=> s_q.src[`ASE_SRC_ACTIVE])
    else $error("latched event lost");

  chk_src_read_clr: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    src_rd && !act |=> s_q.src == `ASE_BYTE_ZERO && !motion_event_interrupt_o)
    else $error("source read did not clear");

  chk_high_detect: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mag(s_q.sample[0]) > {1'b0, thresh_i} |=> s_q.hl[1])
    else $error("x high event missed");

  chk_low_detect: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    mag(s_q.sample[0]) < {1'b0, thresh_i} |=> s_q.hl[0])
    else $error("x low event missed");

  chk_status_map: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_rd && (l_q.addr == `ASE_ADDR_STATUS) |=>
    s_q.rdata == {$past(s_q.all_or), $past(s_q.axis_or),
    $past(s_q.all_nd), $past(s_q.axis_nd)})
    else $error("status layout wrong");

  chk_nd_read_clr: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_out[0] && !smp_vld_i[0] |=> !s_q.axis_nd[0] && !s_q.all_nd)
    else $error("x new data not cleared by read");

  cov_latched_event: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_q.cfg[`ASE_CFG_LATCH] && act ##1 src_rd);

  cov_and_event: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_q.cfg[`ASE_CFG_COMBINE] && act);

  cov_overrun: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(s_q.all_or));

  cov_link_read: cover property (
    @(posedge clk_link_i) disable iff (!lrst_n)
    reg_req_i && !reg_wr_i ##[1:40] l_q.done);

endmodule

// [verif/ase_host_model.sv]
// Host model issuing register accesses on the link clock
`timescale 1ns/10ps
module ase_host_model (
  input wire logic clk_link_i,        // Link clock
  input wire logic [7:0] reg_rdata_i, // Read data
  input wire logic reg_done_i,        // Access finished pulse
  input wire logic reg_busy_i,        // Access in flight
  output logic reg_req_o,             // Request pulse
  output logic reg_wr_o,              // 1 write, 0 read
  output logic [6:0] reg_addr_o,      // Address
  output logic [7:0] reg_wdata_o      // Write data
);
  initial begin
    reg_req_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 7'h7f;
    reg_wdata_o = 8'h00;
  end

  // A read of the source register is how the host clears it
  task automatic access(input logic w, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    int n;
    logic b;
    n = 0;
    b = 1'b0;
    @(posedge clk_link_i);
    while (reg_busy_i !== 1'b0 && n < 16) begin
      @(posedge clk_link_i);
      n++;
    end
    #2;
    reg_req_o = 1'b1;
    reg_wr_o = w;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_link_i);
    #2;
    reg_req_o = 1'b0;
    n = 0;
    do begin
      @(posedge clk_link_i);
      n++;
      b = b | (reg_busy_i === 1'b1);
    end while (reg_done_i !== 1'b1 && n < 12);
    // Busy must show while the access is in flight and drop with done
    ok = (reg_done_i === 1'b1) && (reg_busy_i === 1'b0) && b;
    q = reg_rdata_i;
    // Released qualifiers show the inverse, not a stale copy
    #2;
    reg_wr_o = ~w;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// [verif/accel_status_output_event_config_test.sv]
// Self-checking bench for the status, sample and motion event slice
`timescale 1ns/10ps
module accel_status_output_event_config_test;
  import ase_pkg::*;
  logic clk_sys_i, clk_link_i, rst_n_i;
  logic [7:0] smp_x, smp_y, smp_z, rdata, wdata;
  logic [2:0] smp_vld;
  logic [6:0] thresh, addr;
  logic irq, req, wr, done, busy;
  int errors, compares;

  ase_core dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .smp_x_i(smp_x), .smp_y_i(smp_y), .smp_z_i(smp_z),
    .smp_vld_i(smp_vld), .thresh_i(thresh),
    .motion_event_interrupt_o(irq), .clk_link_i(clk_link_i),
    .reg_req_i(req), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_done_o(done),
    .reg_busy_o(busy));
  ase_host_model host (.clk_link_i(clk_link_i), .reg_rdata_i(rdata),
    .reg_done_i(done), .reg_busy_i(busy), .reg_req_o(req),
    .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata));

  // ****************************************
  // Clocks and watchdog
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Odd offset keeps the link clock out of phase with the system one
  initial begin
    clk_link_i = 1'b0;
    #13;
    forever #40 clk_link_i = ~clk_link_i;
  end
  initial begin
    #500us;
    errors++;
    $display("FAIL watchdog expected finish seen timeout");
    finish_test();
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic access(input logic w, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    logic ok;
    host.access(w, a, d, q, ok);
    check("done", {7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    access(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), q, exp);
  endtask

  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask

  // Waits long enough for the source register and interrupt to settle
  task automatic chk_irq(input logic exp);
    repeat (4) @(posedge clk_sys_i);
    check("irq", {7'h00, irq}, {7'h00, exp});
  endtask

  task automatic send(input logic [2:0] m, input logic [7:0] x,
                      input logic [7:0] y, input logic [7:0] z);
    @(posedge clk_sys_i);
    #2;
    smp_x = x;
    smp_y = y;
    smp_z = z;
    smp_vld = m;
    @(posedge clk_sys_i);
    #2;
    smp_vld = 3'h0;
    smp_x = ~x;
    smp_y = ~y;
    smp_z = ~z;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(7'h27, 8'h00);
    rd(7'h30, 8'h00);
    rd(7'h31, 8'h00);
    chk_irq(1'b0);
    $display("test reset done");
  endtask

  task automatic t_flags;
    send(3'h1, 8'h11, 8'h00, 8'h00);
    rd(7'h27, 8'h01);
    send(3'h6, 8'h00, 8'h22, 8'h33);
    rd(7'h27, 8'h0f);
    rd(7'h29, 8'h11);
    rd(7'h27, 8'h06);
    wreg(7'h29, 8'haa);
    rd(7'h29, 8'h11);
    rd(7'h2a, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_overrun;
    send(3'h2, 8'h00, 8'h44, 8'h00);
    rd(7'h27, 8'h26);
    send(3'h1, 8'h55, 8'h00, 8'h00);
    send(3'h4, 8'h00, 8'h00, 8'h66);
    rd(7'h27, 8'hef);
    rd(7'h2b, 8'h44);
    rd(7'h2d, 8'h66);
    rd(7'h29, 8'h55);
    rd(7'h27, 8'h00);
    $display("test overrun done");
  endtask

  task automatic t_events;
    wreg(7'h30, 8'h03);
    rd(7'h30, 8'h03);
    chk_irq(1'b1);
    rd(7'h31, 8'h42);
    send(3'h1, 8'h05, 8'h00, 8'h00);
    rd(7'h31, 8'h41);
    send(3'h1, 8'hb0, 8'h00, 8'h00);
    rd(7'h31, 8'h42);
    send(3'h1, 8'h05, 8'h00, 8'h00);
    wreg(7'h30, 8'h0a);
    chk_irq(1'b1);
    wreg(7'h30, 8'h8a);
    chk_irq(1'b0);
    send(3'h1, 8'h55, 8'h00, 8'h00);
    chk_irq(1'b1);
    $display("test events done");
  endtask

  task automatic t_latch;
    wreg(7'h30, 8'h42);
    // Bits already in the source register stay once latching starts
    rd(7'h31, 8'h4a);
    send(3'h1, 8'h05, 8'h00, 8'h00);
    rd(7'h31, 8'h42);
    rd(7'h31, 8'h00);
    chk_irq(1'b0);
    send(3'h1, 8'h60, 8'h00, 8'h00);
    chk_irq(1'b1);
    rd(7'h31, 8'h42);
    $display("test latch done");
  endtask

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset spans enough link edges for the link domain to clear too
  initial begin
    errors = 0;
    compares = 0;
    rst_n_i = 1'b0;
    smp_x = 8'h00;
    smp_y = 8'h00;
    smp_z = 8'h00;
    smp_vld = 3'h0;
    thresh = 7'h20;
    repeat (8) @(posedge clk_sys_i);
    #2;
    rst_n_i = 1'b1;
    repeat (4) @(posedge clk_link_i);
    t_reset();
    t_flags();
    t_overrun();
    t_events();
    t_latch();
    finish_test();
  end
endmodule
